// >>> hdl/prfg_replay_top.sv
// Pattern replay controller with per-group thermal fault guard on two modules.
// Assumes an APB master, synchronous trigger and thermal shutdown inputs.
//
// What this block does
// - Hot group driver disables that whole group
// - Disabled groups return only after fault read
// - Hot shared driver disables whole module
// - Fault bits 0-4 and 16-20, rest zero
// - Group flags ordered by output nibble
// - Several faults reported together in one word
// - Flags latched until read; idle word zero
// - Fault status is one 32-bit word
// - Fault read invalidates stored pattern
// - One-pass mode replays memory once after trigger
// - External or software trigger starts output in one-pass and loop modes
// - Loop wraps last to first without gap
// - Loop mode never ends without halt
// - Both controls clear: loop at start immediately
// - Post-trigger mode ends after programmed count
// - Replay length sets pattern length
// - After-trigger count register sets sample count
// - Halt command stops replay at once
`timescale 1ns/1ps
module prfg_replay_top #(
  parameter int ADDR_W = 10
) (
  input  logic                 clk_sys,
  input  logic                 rstn,
  input  logic                 psel,
  input  logic                 penable,
  input  logic                 pwrite,
  input  logic [19:0]          paddr,
  input  logic [31:0]          pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  logic                 trig_in,
  input  prfg_pkg::prfg_therm_t therm,
  output prfg_pkg::prfg_pins_t pins,
  output logic                 running
);

  localparam logic [ADDR_W:0] DEPTH    = {1'b1, {ADDR_W{1'b0}}};
  localparam logic [ADDR_W:0] LEN_ZERO = '0;

  logic                  rst_meta;
  logic                  rst_n_sync;
  logic                  one_pass;
  logic                  loop_sel;
  logic [ADDR_W:0]       replay_length;
  logic [31:0]           after_count;
  logic [ADDR_W-1:0]     mem_ptr;
  logic                  pattern_valid;
  logic [31:0]           faults;
  logic                  trig_q;
  logic                  play_d;
  logic [31:0]           mem_q;
  prfg_pkg::prfg_state_t state;
  prfg_pkg::prfg_state_t next_state;
  logic [ADDR_W-1:0]     rd_addr;
  logic [ADDR_W-1:0]     next_rd_addr;
  logic [31:0]           post_left;
  logic [31:0]           next_post_left;

  // Reset release through two flops; rstn itself only clears them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  // Bus phase and address decode
  wire setup      = psel & ~penable;
  wire wr_done    = psel & penable & pready & pwrite;
  wire rd_done    = psel & penable & pready & ~pwrite;
  wire sel_cmd    = (paddr == prfg_pkg::ADDR_COMMAND);
  wire sel_len    = (paddr == prfg_pkg::ADDR_REPLAY_LENGTH);
  wire sel_after  = (paddr == prfg_pkg::ADDR_AFTER_COUNT);
  wire sel_once   = (paddr == prfg_pkg::ADDR_ONE_PASS);
  wire sel_loop   = (paddr == prfg_pkg::ADDR_LOOP);
  wire sel_fault  = (paddr == prfg_pkg::ADDR_FAULT_FLAGS);
  wire sel_ptr    = (paddr == prfg_pkg::ADDR_MEM_POINTER);
  wire sel_data   = (paddr == prfg_pkg::ADDR_MEM_DATA);
  wire sel_status = (paddr == prfg_pkg::ADDR_RUN_STATUS);
  wire mapped     = sel_cmd | sel_len | sel_after | sel_once | sel_loop
                  | sel_fault | sel_ptr | sel_data | sel_status;

  // Command decode
  wire cmd_wr    = wr_done & sel_cmd;
  wire len_ok    = (replay_length != LEN_ZERO) && (replay_length <= DEPTH);
  wire start_req = cmd_wr && (pwdata == prfg_pkg::CMD_START)
                   && pattern_valid && len_ok && (state == prfg_pkg::PRFG_IDLE);
  wire halt_req  = cmd_wr && (pwdata == prfg_pkg::CMD_HALT);
  wire soft_trig = cmd_wr && (pwdata == prfg_pkg::CMD_SOFT_TRIGGER);
  wire trig_evt  = (trig_in & ~trig_q) | soft_trig;
  wire mem_we    = wr_done & sel_data;
  wire flt_read  = rd_done & sel_fault;

  // Run status flags
  wire playing   = (state == prfg_pkg::PRFG_RUN) | (state == prfg_pkg::PRFG_PRE)
                 | (state == prfg_pkg::PRFG_POST);
  wire triggered = (state == prfg_pkg::PRFG_RUN) | (state == prfg_pkg::PRFG_POST);
  wire [31:0] run_word = {29'h0000_0000, pattern_valid, triggered, running};

  // Read selection; unmapped reads return zero
  wire [31:0] rd_value =
      sel_cmd    ? 32'h0000_0000 :
      sel_len    ? {{(31-ADDR_W){1'b0}}, replay_length} :
      sel_after  ? after_count :
      sel_once   ? {31'h0000_0000, one_pass} :
      sel_loop   ? {31'h0000_0000, loop_sel} :
      sel_fault  ? faults :
      sel_ptr    ? {{(32-ADDR_W){1'b0}}, mem_ptr} :
      sel_status ? run_word : 32'h0000_0000;

  // No wait state: data captured in setup, pready raised for the access
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_value : prdata;
    end
  end

  // Software-written settings
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      one_pass      <= prfg_pkg::RESET_ONE_PASS;
      loop_sel      <= prfg_pkg::RESET_LOOP;
      replay_length <= LEN_ZERO;
      after_count   <= prfg_pkg::RESET_AFTER_COUNT;
    end else if (wr_done) begin
      one_pass      <= sel_once ? pwdata[0] : one_pass;
      loop_sel      <= sel_loop ? pwdata[0] : loop_sel;
      replay_length <= sel_len ? pwdata[ADDR_W:0] : replay_length;
      after_count   <= sel_after ? pwdata : after_count;
    end
  end

  // Memory load pointer auto-increments; a fault read marks the pattern stale
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      mem_ptr       <= '0;
      pattern_valid <= 1'b0;
    end else begin
      if (wr_done & sel_ptr) begin
        mem_ptr <= pwdata[ADDR_W-1:0];
      end else if (mem_we) begin
        mem_ptr <= mem_ptr + 1'b1;
      end
      if (flt_read) begin
        pattern_valid <= 1'b0;
      end else if (mem_we) begin
        pattern_valid <= 1'b1;
      end
    end
  end

  // Fault sources per module: either driver of a group, or the shared driver
  logic [31:0] fault_set;
  logic [31:0] oe_mask;
  genvar m;
  genvar g;
  generate
    for (m = 0; m < prfg_pkg::NUM_MODULES; m++) begin : g_mod
      logic [3:0] grp_hot;
      logic [prfg_pkg::MOD_OUT_WIDTH-1:0] mod_oe;
      for (g = 0; g < prfg_pkg::GROUPS_PER_MOD; g++) begin : g_grp
        assign grp_hot[g] = |therm.group_drv[m][2*g+1:2*g];
        assign mod_oe[g*prfg_pkg::GROUP_WIDTH +: prfg_pkg::GROUP_WIDTH] =
            {prfg_pkg::GROUP_WIDTH{~faults[m*prfg_pkg::FAULT_MOD_STRIDE + g]}};
      end
      assign fault_set[m*prfg_pkg::FAULT_MOD_STRIDE +: prfg_pkg::FAULT_MOD_STRIDE] =
          {11'h000, therm.shared[m], grp_hot};
      assign oe_mask[m*prfg_pkg::MOD_OUT_WIDTH +: prfg_pkg::MOD_OUT_WIDTH] =
          faults[m*prfg_pkg::FAULT_MOD_STRIDE + prfg_pkg::FAULT_MODULE_BIT]
          ? 16'h0000 : mod_oe;
    end
  endgenerate

  // Only bits actually returned by the read are cleared, so a new fault wins
  wire [31:0] clear_mask = flt_read ? prdata : 32'h0000_0000;
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      faults <= prfg_pkg::RESET_FAULTS;
    end else begin
      faults <= (faults & ~clear_mask) | fault_set;
    end
  end

  // Sequencer next-state logic; halt overrides every mode
  wire [ADDR_W:0]   len_m1    = replay_length - 1'b1;
  wire              last      = (rd_addr == len_m1[ADDR_W-1:0]);
  wire [ADDR_W-1:0] wrap_addr = last ? '0 : rd_addr + 1'b1;
  always_comb begin
    next_state     = state;
    next_rd_addr   = rd_addr;
    next_post_left = post_left;
    case (state)
      prfg_pkg::PRFG_IDLE: begin
        if (start_req) begin
          next_rd_addr = '0;
          next_state   = (one_pass | loop_sel) ? prfg_pkg::PRFG_ARMED
                                               : prfg_pkg::PRFG_PRE;
        end
      end
      prfg_pkg::PRFG_ARMED: begin
        if (trig_evt) begin
          next_state   = prfg_pkg::PRFG_RUN;
          next_rd_addr = '0;
        end
      end
      prfg_pkg::PRFG_RUN: begin
        next_rd_addr = wrap_addr;
        if (last && one_pass) begin
          next_state = prfg_pkg::PRFG_IDLE;
        end
      end
      prfg_pkg::PRFG_PRE: begin
        next_rd_addr = wrap_addr;
        if (trig_evt) begin
          next_post_left = after_count;
          next_state     = (after_count == 32'h0000_0000) ? prfg_pkg::PRFG_IDLE
                                                          : prfg_pkg::PRFG_POST;
        end
      end
      prfg_pkg::PRFG_POST: begin
        next_rd_addr   = wrap_addr;
        next_post_left = post_left - 32'h0000_0001;
        if (post_left == 32'h0000_0001) begin
          next_state = prfg_pkg::PRFG_IDLE;
        end
      end
      default: begin
        next_state = prfg_pkg::PRFG_IDLE;
      end
    endcase
    if (halt_req) begin
      next_state = prfg_pkg::PRFG_IDLE;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state     <= prfg_pkg::PRFG_IDLE;
      rd_addr   <= '0;
      post_left <= 32'h0000_0000;
      trig_q    <= 1'b0;
    end else begin
      state     <= next_state;
      rd_addr   <= next_rd_addr;
      post_left <= next_post_left;
      trig_q    <= trig_in;
    end
  end

  prfg_pattern_mem #(
    .DATA_W (32),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk   (clk_sys),
    .we    (mem_we),
    .waddr (mem_ptr),
    .wdata (pwdata),
    .raddr (rd_addr),
    .rdata (mem_q)
  );

  // Pins follow memory by one cycle; faulted bits never drive
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      play_d    <= 1'b0;
      running   <= 1'b0;
      pins.data <= 32'h0000_0000;
      pins.oe   <= 32'h0000_0000;
    end else begin
      play_d    <= playing;
      running   <= playing;
      pins.data <= play_d ? (mem_q & oe_mask) : 32'h0000_0000;
      pins.oe   <= play_d ? oe_mask : 32'h0000_0000;
    end
  end

  // Checks run on the synchronised reset, all on the system clock
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n_sync);

  sequence s_group_hot;
    therm.group_drv[0][2] && play_d && playing;
  endsequence

  sequence s_halt_settle;
    (state == prfg_pkg::PRFG_IDLE) ##2 !running;
  endsequence

  a_group_gated: assert property (s_group_hot |-> ##2 (pins.oe[7:4] == 4'h0))
    else $error("Hot group still driving");
  a_module_gated: assert property (therm.shared[1] |-> ##2 (pins.oe[31:16] == 16'h0000))
    else $error("Module not gated on shared fault");
  a_flag_sticky: assert property (faults[16] && !clear_mask[16] |=> faults[16])
    else $error("Fault flag dropped without read");
  a_read_clear: assert property (flt_read |=>
      ((faults & $past(prdata)) == ($past(fault_set) & $past(prdata))))
    else $error("Fault read cleared wrong bits");
  a_unused_zero: assert property ((faults & ~prfg_pkg::FAULT_USED_MASK) == 32'h0000_0000)
    else $error("Unused fault bit set");
  a_read_stale: assert property (flt_read |=> !pattern_valid)
    else $error("Pattern still valid after fault read");
  a_stale_refuse: assert property ((state == prfg_pkg::PRFG_IDLE) && cmd_wr && !pattern_valid
      && (pwdata == prfg_pkg::CMD_START) |=> (state == prfg_pkg::PRFG_IDLE))
    else $error("Start taken on stale pattern");
  a_set_wins: assert property ((fault_set != 32'h0000_0000)
      |=> ((faults & $past(fault_set)) == $past(fault_set)))
    else $error("Simultaneous fault flag lost");
  a_once_end: assert property ((state == prfg_pkg::PRFG_RUN) && one_pass && last
      |=> (state == prfg_pkg::PRFG_IDLE))
    else $error("One pass did not stop");
  a_loop_wrap: assert property ((state == prfg_pkg::PRFG_RUN) && !one_pass && last && !halt_req
      |=> (state == prfg_pkg::PRFG_RUN) && (rd_addr == '0))
    else $error("Loop did not wrap to first sample");
  a_pre_start: assert property (start_req && !one_pass && !loop_sel
      |=> (state == prfg_pkg::PRFG_PRE))
    else $error("Untriggered loop did not start");
  a_post_end: assert property ((state == prfg_pkg::PRFG_POST) && (post_left == 32'h0000_0001)
      |=> (state == prfg_pkg::PRFG_IDLE))
    else $error("Post count overran");
  a_halt_now: assert property (halt_req |=> s_halt_settle)
    else $error("Halt ignored");

endmodule

// >>> hdl/prfg_pkg.sv
// Package for the pattern replay and fault guard block: register map,
// command codes, fault word layout, reset values, state encoding and carriers.
// Assumes a 32-bit APB register bus and two output modules of sixteen bits.
package prfg_pkg;

  // Byte addresses on the register bus
  localparam logic [19:0] ADDR_COMMAND       = 20'h0_0000;
  localparam logic [19:0] ADDR_REPLAY_LENGTH = 20'h0_2710;
  localparam logic [19:0] ADDR_AFTER_COUNT   = 20'h0_2774;
  localparam logic [19:0] ADDR_ONE_PASS      = 20'h0_a028;
  localparam logic [19:0] ADDR_LOOP          = 20'h0_a08c;
  localparam logic [19:0] ADDR_FAULT_FLAGS   = 20'h3_24b0;
  localparam logic [19:0] ADDR_MEM_POINTER   = 20'h0_0100;
  localparam logic [19:0] ADDR_MEM_DATA      = 20'h0_0104;
  localparam logic [19:0] ADDR_RUN_STATUS    = 20'h0_0108;

  // Values written to the command word
  localparam logic [31:0] CMD_START        = 32'h0000_000a;
  localparam logic [31:0] CMD_HALT         = 32'h0000_0014;
  localparam logic [31:0] CMD_SOFT_TRIGGER = 32'h0000_001e;

  // Fault word layout
  localparam int          NUM_MODULES      = 2;
  localparam int          GROUPS_PER_MOD   = 4;
  localparam int          GROUP_WIDTH      = 4;
  localparam int          MOD_OUT_WIDTH    = 16;
  localparam int          FAULT_MOD_STRIDE = 16;
  localparam int          FAULT_MODULE_BIT = 4;
  localparam logic [31:0] FAULT_USED_MASK  = 32'h001f_001f;

  // Run status word bit positions
  localparam int RUN_BIT_RUNNING   = 0;
  localparam int RUN_BIT_TRIGGERED = 1;
  localparam int RUN_BIT_VALID     = 2;

  // Reset values
  localparam logic [31:0] RESET_FAULTS      = 32'h0000_0000;
  localparam logic [31:0] RESET_AFTER_COUNT = 32'h0000_0000;
  localparam logic        RESET_ONE_PASS    = 1'b0;
  localparam logic        RESET_LOOP        = 1'b0;

  // Replay sequencer states
  typedef enum logic [2:0] {
    PRFG_IDLE  = 3'b000,
    PRFG_ARMED = 3'b001,
    PRFG_RUN   = 3'b010,
    PRFG_PRE   = 3'b011,
    PRFG_POST  = 3'b100
  } prfg_state_t;

  // Thermal shutdown lines of both modules, two drivers per group
  typedef struct packed {
    logic [NUM_MODULES-1:0]      shared;
    logic [NUM_MODULES-1:0][7:0] group_drv;
  } prfg_therm_t;

  // Pattern output pins with their per-bit drive enables
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] oe;
  } prfg_pins_t;

endpackage

// >>> hdl/prfg_pattern_mem.sv
// Pattern sample memory: one write port, one read port with registered data.
// Assumes a single clock; read data appear one cycle after the address.
`timescale 1ns/1ps
module prfg_pattern_mem #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 10
) (
  input  logic              clk,
  input  logic              we,
  input  logic [ADDR_W-1:0] waddr,
  input  logic [DATA_W-1:0] wdata,
  input  logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

  // No reset on the array so it maps onto block memory
  always_ff @(posedge clk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
    rdata <= store[raddr];
  end

endmodule

// >>> testbench/prfg_load_model.sv
// Load model on the pattern pins: line drivers that overheat on demand.
// Assumes the bench raises heat bits to mimic a short; shutdown lines follow one clock later.
`timescale 1ns/1ps
module prfg_load_model (
  input  logic                  clk_sys,
  input  prfg_pkg::prfg_pins_t  pins,
  input  logic [17:0]           heat,
  output prfg_pkg::prfg_therm_t therm
);
  // Shutdown lines are synchronous levels, so register them like a real sensor
  initial therm = '0;
  always @(posedge clk_sys) begin
    therm <= prfg_pkg::prfg_therm_t'(heat);
  end
endmodule

// >>> testbench/tb_prfg_replay_top.sv
// Self-checking bench for the pattern replay and fault guard block.
// Assumes the load model beside it and the design package; depth shrunk to 16.
`timescale 1ns/1ps
module tb_prfg_replay_top;
  localparam int LEN = 5;
  localparam int AFT = 7;
  logic                  clk_sys, rstn, psel, penable, pwrite, trig_in;
  logic [19:0]           paddr;
  logic [31:0]           pwdata, prdata, rd, v;
  logic                  pready, pslverr, running, err;
  logic [17:0]           heat;
  prfg_pkg::prfg_therm_t therm;
  prfg_pkg::prfg_pins_t  pins;
  logic [31:0]           mem_q[$];
  int                    miscompares, total_checks, seed, n;

  prfg_replay_top #(.ADDR_W(4)) i_prfg_replay_top (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .therm(therm), .pins(pins), .running(running));
  prfg_load_model i_prfg_load_model (.clk_sys(clk_sys), .pins(pins), .heat(heat),
    .therm(therm));

  // Free running system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    miscompares++;
    $display("ERROR %s expected event seen none", what);
    complete_run();
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus cycle: request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [19:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, exp, rd);
  endtask

  // Fresh random pattern into memory, shadowed in the model queue
  task automatic load();
    mem_q.delete();
    wr(prfg_pkg::ADDR_MEM_POINTER, 32'h0000_0000);
    for (int i = 0; i < LEN; i++) begin
      mem_q.push_back($random(seed));
      wr(prfg_pkg::ADDR_MEM_DATA, mem_q[i]);
    end
    wr(prfg_pkg::ADDR_REPLAY_LENGTH, 32'(LEN));
  endtask

  // Expected drive enables for a given fault word
  function automatic logic [31:0] exp_oe(input logic [31:0] f);
    logic [31:0] o;
    o = '1;
    for (int b = 0; b < 32; b++) begin
      if (f[16*(b/16)+4] || f[16*(b/16)+(b%16)/4]) o[b] = 1'b0;
    end
    return o;
  endfunction

  task automatic wait_oe(input logic [31:0] exp);
    for (n = 0; n < 10 && pins.oe !== exp; n++) @(negedge clk_sys);
    check("pins.oe", exp, pins.oe);
  endtask

  // Consecutive samples from the first driven cycle, wrapping through memory
  task automatic stream(input int cnt);
    for (n = 0; n < 40 && pins.oe === 32'h0000_0000; n++) @(negedge clk_sys);
    if (n == 40) timeout("first sample");
    for (int i = 0; i < cnt; i++) begin
      check("pins.oe", 32'hffff_ffff, pins.oe);
      check("pins.data", mem_q[i % LEN], pins.data);
      @(negedge clk_sys);
    end
  endtask

  initial begin
    seed = 32'h2784;
    {psel, penable, pwrite, trig_in, rstn} = '0;
    {paddr, pwdata, heat} = '0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Reset values, access kinds and an unmapped place
    rdchk("fault word", prfg_pkg::ADDR_FAULT_FLAGS, 32'h0000_0000);
    rdchk("loop_select", prfg_pkg::ADDR_LOOP, 32'h0000_0000);
    wr(prfg_pkg::ADDR_ONE_PASS, 32'h0000_0001);
    rdchk("one_pass_select", prfg_pkg::ADDR_ONE_PASS, 32'h0000_0001);
    rdchk("unmapped", 20'h0_0ffc, 32'h0000_0000);
    check("pslverr", 32'h0000_0001, {31'h0, err});
    $display("test registers done");
    // One pass, started by the software trigger
    load();
    rdchk("replay_length", prfg_pkg::ADDR_REPLAY_LENGTH, 32'(LEN));
    rdchk("mem pointer", prfg_pkg::ADDR_MEM_POINTER, 32'(LEN));
    wr(prfg_pkg::ADDR_COMMAND, prfg_pkg::CMD_START);
    repeat (4) @(negedge clk_sys);
    check("armed oe", 32'h0000_0000, pins.oe);
    rdchk("run status", prfg_pkg::ADDR_RUN_STATUS, 32'h0000_0004);
    wr(prfg_pkg::ADDR_COMMAND, prfg_pkg::CMD_SOFT_TRIGGER);
    stream(LEN);
    check("end oe", 32'h0000_0000, pins.oe);
    repeat (3) @(negedge clk_sys);
    check("running", 32'h0000_0000, {31'h0, running});
    $display("test one pass done");
    // Looping on an external trigger edge
    wr(prfg_pkg::ADDR_ONE_PASS, 32'h0000_0000);
    wr(prfg_pkg::ADDR_LOOP, 32'h0000_0001);
    wr(prfg_pkg::ADDR_COMMAND, prfg_pkg::CMD_START);
    @(posedge clk_sys);
    trig_in <= 1'b1;
    stream(3 * LEN);
    rdchk("run status", prfg_pkg::ADDR_RUN_STATUS, 32'h0000_0007);
    trig_in <= 1'b0;
    $display("test loop done");
    // Thermal faults while looping: group, then whole module, then cool down
    heat <= 18'h0_0004;
    wait_oe(exp_oe(32'h0000_0002));
    @(posedge clk_sys);
    heat <= 18'h2_0004;
    wait_oe(exp_oe(32'h0010_0002));
    @(posedge clk_sys);
    heat <= 18'h0_0000;
    repeat (6) @(negedge clk_sys);
    check("cool oe", exp_oe(32'h0010_0002), pins.oe);
    rdchk("fault word", prfg_pkg::ADDR_FAULT_FLAGS, 32'h0010_0002);
    wait_oe(32'hffff_ffff);
    rdchk("fault word", prfg_pkg::ADDR_FAULT_FLAGS, 32'h0000_0000);
    // One-cycle fault pulses at shifting offsets around a read
    for (int k = 0; k < 4; k++) begin
      fork
        apb(1'b0, prfg_pkg::ADDR_FAULT_FLAGS, 32'h0000_0000);
        begin
          repeat (k + 1) @(posedge clk_sys);
          heat <= 18'h0_0100;
          @(posedge clk_sys);
          heat <= 18'h0_0000;
        end
      join
      v = rd;
      repeat (3) @(posedge clk_sys);
      apb(1'b0, prfg_pkg::ADDR_FAULT_FLAGS, 32'h0000_0000);
      check("pulse flag", 32'h0001_0000, v | rd);
    end
    wr(prfg_pkg::ADDR_COMMAND, prfg_pkg::CMD_HALT);
    wait_oe(32'h0000_0000);
    check("running", 32'h0000_0000, {31'h0, running});
    $display("test faults done");
    // A fault read left memory stale, so start is refused until reload
    wr(prfg_pkg::ADDR_COMMAND, prfg_pkg::CMD_START);
    repeat (5) @(negedge clk_sys);
    check("stale start", 32'h0000_0000, {31'h0, running});
    // Post-trigger mode: loops at once, ends a set count after the trigger
    load();
    wr(prfg_pkg::ADDR_LOOP, 32'h0000_0000);
    wr(prfg_pkg::ADDR_AFTER_COUNT, 32'(AFT));
    rdchk("after count", prfg_pkg::ADDR_AFTER_COUNT, 32'(AFT));
    wr(prfg_pkg::ADDR_COMMAND, prfg_pkg::CMD_START);
    stream(2 * LEN);
    rdchk("run status", prfg_pkg::ADDR_RUN_STATUS, 32'h0000_0005);
    wr(prfg_pkg::ADDR_COMMAND, prfg_pkg::CMD_SOFT_TRIGGER);
    for (n = 0; n < 40 && running === 1'b1; n++) @(negedge clk_sys);
    check("post length", 32'h0000_0001, {31'h0, n >= AFT && n <= AFT + 4});
    repeat (3) @(negedge clk_sys);
    check("post oe", 32'h0000_0000, pins.oe);
    $display("test post trigger done");
    complete_run();
  end
endmodule
